// [sftc_pkg.sv]
package sftc_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_FIFO_CONTROL = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h0C;
  localparam logic [7:0] OFS_LEVELS       = 8'h10;

  // Control register reset value and writable masks
  localparam logic [15:0] FCR_RESET       = 16'h0000;
  localparam logic [15:0] FCR_MASK_FLOW   = 16'h07FF;  // Channel with flow control
  localparam logic [15:0] FCR_MASK_NOFLOW = 16'h00F7;  // Flow field and modem enable absent

  // Control register field positions
  localparam int unsigned FLOW_LSB  = 8;
  localparam int unsigned RX_TRG_LSB = 6;
  localparam int unsigned TX_TRG_LSB = 4;
  localparam int unsigned MODEM_EN_BIT = 3;
  localparam int unsigned TXCLR_BIT  = 2;
  localparam int unsigned RXCLR_BIT  = 1;
  localparam int unsigned LOOP_BIT   = 0;

  // Interrupt status bit positions
  localparam int unsigned IRQ_RTS = 0;
  localparam int unsigned IRQ_RXF = 1;
  localparam int unsigned IRQ_TXE = 2;
  localparam int unsigned IRQ_W   = 3;

  // Level register field positions
  localparam int unsigned LVL_RX_LSB  = 0;
  localparam int unsigned LVL_TX_LSB  = 8;
  localparam int unsigned LVL_RTS_BIT = 16;
  localparam int unsigned LVL_RXF_BIT = 17;
  localparam int unsigned LVL_TXE_BIT = 18;
  localparam int unsigned LVL_CTS_BIT = 19;

  // FIFO sizes and pin synchroniser reset levels
  localparam int unsigned TX_DEPTH  = 16;
  localparam int unsigned CNT_W     = 5;
  localparam logic        PIN_IDLE  = 1'b1;

  // Threshold tables indexed by the field codes
  localparam logic [4:0] FLOW_THR     [8] = '{5'h0F, 5'h01, 5'h04, 5'h06,
                                              5'h08, 5'h0A, 5'h0C, 5'h0E};
  localparam logic [4:0] RX_THR_ASYNC [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam logic [4:0] RX_THR_SYNC  [4] = '{5'h01, 5'h02, 5'h08, 5'h0E};
  localparam logic [4:0] TX_THR       [4] = '{5'h08, 5'h04, 5'h02, 5'h00};

  // Control register layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] flow_thr;
    logic [1:0] rx_trg;
    logic [1:0] tx_trg;
    logic       modem_ctrl_enable;
    logic       tx_fifo_clear;
    logic       rx_fifo_clear;
    logic       loop;
  } sftc_fcr_t;

  // FIFO fill levels from the data path
  typedef struct packed {
    logic [4:0] tx_count;
    logic [4:0] rx_count;
  } sftc_levels_t;

endpackage : sftc_pkg

// [sftc_pin_sync.sv]
module sftc_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic mclk_in,    // Peripheral clock
  input  wire logic rst_n_in,   // Async reset, active low
  input  wire logic pin_in,     // Asynchronous pin level
  output logic      level_out   // Filtered level
);

  logic stage1_ff;
  logic stage2_ff;
  logic stage3_ff;
  logic level_ff;
  logic nxt_level;

  // Accept a change only once stages two and three agree
  always_comb begin
    nxt_level = level_ff;
    if (stage2_ff == stage3_ff) begin
      nxt_level = stage3_ff;
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
      level_ff  <= RESET_VAL;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff  <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule : sftc_pin_sync

// [sftc_fifo_ctrl.sv]
// Contract
// - Power-on reset clears control register
// - Bits 15..11 read zero, write zero
// - Flow field sets request high above threshold
// - Flow field absent on third channel
// - Async receive-full thresholds 1,4,8,14
// - Sync receive-full thresholds 1,2,8,14
// - Transmit-empty thresholds 8,4,2,0
// - Transmit FIFO holds sixteen entries
// - Control register accessible at any time
// - Modem disabled: CTS active, request low
// - Bit 2 empties transmit FIFO
// - Bit 1 empties receive FIFO
// - Bit 0 loops transmit to receive
module sftc_fifo_ctrl #(
  parameter logic FLOW_CTRL = 1'b1   // Zero for a channel without flow control
) (
  input  wire logic                 mclk_in,           // Peripheral clock, 20 MHz
  input  wire logic                 rst_n_in,          // Power-on reset, active low
  input  wire logic [7:0]           paddr_in,          // APB byte address
  input  wire logic                 psel_in,           // APB select
  input  wire logic                 penable_in,        // APB access phase
  input  wire logic                 pwrite_in,         // APB write
  input  wire logic [31:0]          pwdata_in,         // APB write data
  input  wire logic [3:0]           pstrb_in,          // APB byte strobes
  output logic [31:0]               prdata_out,        // APB read data
  output logic                      pready_out,        // APB ready
  output logic                      pslverr_out,       // APB error, unmapped
  input  wire sftc_pkg::sftc_levels_t levels_in,       // FIFO fill levels
  input  wire logic                 sync_mode_in,      // Clocked synchronous mode
  input  wire logic                 cts_n_pin_in,      // Clear-to-send pin
  input  wire logic                 rxd_pin_in,        // Receive data pin
  input  wire logic                 tx_serial_in,      // Transmitter serial out
  output logic                      rts_out,           // Request-to-send pin level
  output logic                      cts_active_out,    // Internal clear-to-send
  output logic                      rx_full_out,       // Receive-full flag
  output logic                      tx_empty_out,      // Transmit-empty flag
  output logic                      tx_fifo_clear_out, // Hold transmit FIFO empty
  output logic                      rx_fifo_clear_out, // Hold receive FIFO empty
  output logic                      rx_serial_out,     // Receiver serial in
  output logic                      txd_pin_out,       // Transmit data pin
  output logic                      irq_out            // Interrupt, level
);

  localparam logic [15:0] WR_MASK = FLOW_CTRL ? sftc_pkg::FCR_MASK_FLOW
                                              : sftc_pkg::FCR_MASK_NOFLOW;

  sftc_pkg::sftc_fcr_t fcr_ff;
  sftc_pkg::sftc_fcr_t nxt_fcr;
  logic [31:0]         prdata_ff;
  logic [31:0]         nxt_prdata;
  logic                pslverr_ff;
  logic                nxt_pslverr;
  logic [sftc_pkg::IRQ_W-1:0] irq_status_ff;
  logic [sftc_pkg::IRQ_W-1:0] nxt_irq_status;
  logic [sftc_pkg::IRQ_W-1:0] irq_enable_ff;
  logic [sftc_pkg::IRQ_W-1:0] nxt_irq_enable;
  logic [sftc_pkg::IRQ_W-1:0] irq_clear;
  logic [sftc_pkg::IRQ_W-1:0] irq_event;
  logic                rts_ff;
  logic                nxt_rts;
  logic                rx_full_ff;
  logic                nxt_rx_full;
  logic                tx_empty_ff;
  logic                nxt_tx_empty;
  logic                cts_ff;
  logic                nxt_cts;
  logic                rx_serial_ff;
  logic                nxt_rx_serial;
  logic                txd_ff;
  logic                nxt_txd;
  logic [4:0]          flow_thr;
  logic [4:0]          rx_thr;
  logic [4:0]          tx_thr;
  logic                setup_rd;
  logic                access_wr;
  logic                addr_hit;
  logic                cts_n_sync;
  logic                rxd_sync;

  // Pin inputs pass the agreeing three-stage synchroniser
  sftc_pin_sync #(
    .RESET_VAL (sftc_pkg::PIN_IDLE)
  ) u_cts_sync (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (cts_n_pin_in),
    .level_out (cts_n_sync)
  );

  sftc_pin_sync #(
    .RESET_VAL (sftc_pkg::PIN_IDLE)
  ) u_rxd_sync (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (rxd_pin_in),
    .level_out (rxd_sync)
  );

  // Bus phase decode; zero wait states so access is never stalled
  assign setup_rd   = psel_in && !penable_in && !pwrite_in;
  assign access_wr  = psel_in && penable_in && pwrite_in;
  assign pready_out = 1'b1;
  assign addr_hit   = (paddr_in == sftc_pkg::OFS_FIFO_CONTROL) ||
                      (paddr_in == sftc_pkg::OFS_IRQ_STATUS)   ||
                      (paddr_in == sftc_pkg::OFS_IRQ_CLEAR)    ||
                      (paddr_in == sftc_pkg::OFS_IRQ_ENABLE)   ||
                      (paddr_in == sftc_pkg::OFS_LEVELS);

  // Control and enable registers, byte lanes honoured
  always_comb begin
    nxt_fcr        = fcr_ff;
    nxt_irq_enable = irq_enable_ff;
    irq_clear      = '0;
    if (access_wr && paddr_in == sftc_pkg::OFS_FIFO_CONTROL) begin
      if (pstrb_in[0]) begin
        nxt_fcr[7:0] = pwdata_in[7:0] & WR_MASK[7:0];
      end
      if (pstrb_in[1]) begin
        nxt_fcr[15:8] = pwdata_in[15:8] & WR_MASK[15:8];
      end
    end
    if (access_wr && paddr_in == sftc_pkg::OFS_IRQ_ENABLE && pstrb_in[0]) begin
      nxt_irq_enable = pwdata_in[sftc_pkg::IRQ_W-1:0];
    end
    if (access_wr && paddr_in == sftc_pkg::OFS_IRQ_CLEAR && pstrb_in[0]) begin
      irq_clear = pwdata_in[sftc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fcr_ff        <= sftc_pkg::FCR_RESET;
      irq_enable_ff <= '0;
    end else begin
      fcr_ff        <= nxt_fcr;
      irq_enable_ff <= nxt_irq_enable;
    end
  end

  // Read data captured in setup so it is stable through access
  always_comb begin
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel_in && !penable_in) begin
      nxt_pslverr = !addr_hit;
      nxt_prdata  = 32'h0000_0000;
    end
    if (setup_rd) begin
      case (paddr_in)
        sftc_pkg::OFS_FIFO_CONTROL: begin
          nxt_prdata[15:0] = fcr_ff;
        end
        sftc_pkg::OFS_IRQ_STATUS: begin
          nxt_prdata[sftc_pkg::IRQ_W-1:0] = irq_status_ff;
        end
        sftc_pkg::OFS_IRQ_ENABLE: begin
          nxt_prdata[sftc_pkg::IRQ_W-1:0] = irq_enable_ff;
        end
        sftc_pkg::OFS_LEVELS: begin
          nxt_prdata[sftc_pkg::LVL_RX_LSB +: sftc_pkg::CNT_W] = levels_in.rx_count;
          nxt_prdata[sftc_pkg::LVL_TX_LSB +: sftc_pkg::CNT_W] = levels_in.tx_count;
          nxt_prdata[sftc_pkg::LVL_RTS_BIT] = rts_ff;
          nxt_prdata[sftc_pkg::LVL_RXF_BIT] = rx_full_ff;
          nxt_prdata[sftc_pkg::LVL_TXE_BIT] = tx_empty_ff;
          nxt_prdata[sftc_pkg::LVL_CTS_BIT] = cts_ff;
        end
        default: begin
          nxt_prdata = 32'h0000_0000;  // Clear register and holes read zero
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata_out  = prdata_ff;
  assign pslverr_out = pslverr_ff && psel_in && penable_in;

  // Threshold lookup from the current field codes
  always_comb begin
    flow_thr = sftc_pkg::FLOW_THR[fcr_ff.flow_thr];
    if (sync_mode_in) begin
      rx_thr = sftc_pkg::RX_THR_SYNC[fcr_ff.rx_trg];
    end else begin
      rx_thr = sftc_pkg::RX_THR_ASYNC[fcr_ff.rx_trg];
    end
    tx_thr = sftc_pkg::TX_THR[fcr_ff.tx_trg];
  end

  // Flags compared every clock, so a new setting acts on the next clock
  always_comb begin
    nxt_rts      = FLOW_CTRL && fcr_ff.modem_ctrl_enable &&
                   (levels_in.rx_count > flow_thr);
    nxt_rx_full  = levels_in.rx_count > rx_thr;
    // Count at or below threshold leaves 8/12/14/16 of 16 free
    nxt_tx_empty = levels_in.tx_count <= tx_thr;
    nxt_cts      = !(FLOW_CTRL && fcr_ff.modem_ctrl_enable) || !cts_n_sync;
    // Loop-back feeds the receiver and parks the pin at mark
    nxt_rx_serial = fcr_ff.loop ? tx_serial_in : rxd_sync;
    nxt_txd       = fcr_ff.loop ? 1'b1 : tx_serial_in;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rts_ff       <= 1'b0;
      rx_full_ff   <= 1'b0;
      tx_empty_ff  <= 1'b0;
      cts_ff       <= 1'b1;
      rx_serial_ff <= 1'b1;
      txd_ff       <= 1'b1;
    end else begin
      rts_ff       <= nxt_rts;
      rx_full_ff   <= nxt_rx_full;
      tx_empty_ff  <= nxt_tx_empty;
      cts_ff       <= nxt_cts;
      rx_serial_ff <= nxt_rx_serial;
      txd_ff       <= nxt_txd;
    end
  end

  assign rts_out           = rts_ff;
  assign rx_full_out       = rx_full_ff;
  assign tx_empty_out      = tx_empty_ff;
  assign cts_active_out    = cts_ff;
  assign rx_serial_out     = rx_serial_ff;
  assign txd_pin_out       = txd_ff;
  assign tx_fifo_clear_out = fcr_ff.tx_fifo_clear;
  assign rx_fifo_clear_out = fcr_ff.rx_fifo_clear;

  // Sticky events on rising flags; a set beats a same-cycle clear
  always_comb begin
    irq_event = '0;
    irq_event[sftc_pkg::IRQ_RTS] = nxt_rts && !rts_ff;
    irq_event[sftc_pkg::IRQ_RXF] = nxt_rx_full && !rx_full_ff;
    irq_event[sftc_pkg::IRQ_TXE] = nxt_tx_empty && !tx_empty_ff;
    nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_event;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  assign irq_out = |(irq_status_ff & irq_enable_ff);

  // Checks on the flag, pin and register behaviour
  a_rts_modem_off: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    !fcr_ff.modem_ctrl_enable |=> !rts_out && cts_active_out)
    else $error("request high or CTS inactive with modem control off");

  a_rts_above_thr: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (FLOW_CTRL && fcr_ff.modem_ctrl_enable && fcr_ff.flow_thr == 3'h0 &&
     levels_in.rx_count == 5'h10) |=> rts_out)
    else $error("request not raised above fifteen");

  a_rts_at_thr: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (fcr_ff.flow_thr == 3'h3 && levels_in.rx_count == 5'h06) |=> !rts_out)
    else $error("request raised at six with code three");

  a_rxf_async_lvl: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!sync_mode_in && fcr_ff.rx_trg == 2'h1) |=>
      rx_full_out == ($past(levels_in.rx_count) > 5'h04))
    else $error("async receive-full wrong at trigger four");

  a_rxf_sync_lvl: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (sync_mode_in && fcr_ff.rx_trg == 2'h1) |=>
      rx_full_out == ($past(levels_in.rx_count) > 5'h02))
    else $error("sync receive-full wrong at trigger two");

  a_txe_code_lvl: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (fcr_ff.tx_trg == 2'h0 && levels_in.tx_count == 5'h09)
      ##1 (fcr_ff.tx_trg == 2'h0 && levels_in.tx_count == 5'h08) |=>
      $rose(tx_empty_out))
    else $error("transmit-empty not raised at eight left");

  a_txe_full_off: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (levels_in.tx_count == 5'h10) |=> !tx_empty_out)
    else $error("transmit-empty with sixteen queued");

  a_fcr_rsvd_zero: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (setup_rd && paddr_in == sftc_pkg::OFS_FIFO_CONTROL) |=>
      prdata_out[31:11] == 21'h000000)
    else $error("reserved control bits read nonzero");

  a_txclr_write: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (access_wr && paddr_in == sftc_pkg::OFS_FIFO_CONTROL && pstrb_in[0])
      |=> tx_fifo_clear_out == $past(pwdata_in[sftc_pkg::TXCLR_BIT]))
    else $error("transmit clear not taken from write");

  a_rxclr_write: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (access_wr && paddr_in == sftc_pkg::OFS_FIFO_CONTROL && pstrb_in[0])
      |=> rx_fifo_clear_out == $past(pwdata_in[sftc_pkg::RXCLR_BIT]))
    else $error("receive clear not taken from write");

  a_loop_route: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    fcr_ff.loop |=> rx_serial_out == $past(tx_serial_in) && txd_pin_out)
    else $error("loop-back path not routed");

  a_no_flow_field: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    !FLOW_CTRL |-> fcr_ff.flow_thr == 3'h0 && !fcr_ff.modem_ctrl_enable)
    else $error("flow field set on channel without it");

  // A rising transmit-empty flag must leave its sticky bit set
  a_txe_evt_sticky: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (nxt_tx_empty && !tx_empty_ff) |=> irq_status_ff[sftc_pkg::IRQ_TXE])
    else $error("transmit-empty rise not recorded");

endmodule : sftc_fifo_ctrl

// [sftc_remote_model.sv]
module sftc_remote_model (
  input  wire logic mclk_in,   // Peripheral clock
  input  wire logic rst_n_in,  // Reset, active low
  input  wire logic rts_in,    // Request level from the device
  input  wire logic stall_in,  // Bench: remote not ready
  input  wire logic send_in,   // Bench: remote has data
  input  wire logic bit_in,    // Bench: data bit to send
  output logic      cts_n_out, // Clear-to-send, active low
  output logic      rxd_out    // Serial line into the device
);
  timeunit 1ns;
  timeprecision 1ns;

  // Remote holds off while asked; line idles at mark so a stop is visible
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cts_n_out <= 1'h1;
      rxd_out   <= 1'h1;
    end else begin
      cts_n_out <= stall_in;
      rxd_out   <= (send_in && !rts_in) ? bit_in : 1'h1;
    end
  end
endmodule : sftc_remote_model

// [serial_fifo_trigger_control_tb.sv]
module serial_fifo_trigger_control_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [15:0] fcr;
    logic        sync;
    logic [4:0]  rx;
    logic [4:0]  tx;
    logic [2:0]  exp;  // rts, rx_full, tx_empty
  } sftc_row_t;

  localparam logic [7:0] A_CTRL = sftc_pkg::OFS_FIFO_CONTROL;
  localparam logic [7:0] A_STAT = sftc_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] A_CLR  = sftc_pkg::OFS_IRQ_CLEAR;
  localparam logic [7:0] A_EN   = sftc_pkg::OFS_IRQ_ENABLE;
  localparam logic [7:0] A_LVL  = sftc_pkg::OFS_LEVELS;

  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        sync_mode, tx_serial, stall, send, dbit, cts_n, rxd;
  logic        rts, cts_act, rx_full, tx_empty, txclr, rxclr, rx_serial, txd, irq, rts3;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, prdata3, rd;
  sftc_pkg::sftc_levels_t lv;
  int          n_fail, checked, cyc;

  // Threshold edges: each flow code at its count and one above, then receive-full code edges
  sftc_row_t rows [23] = '{
    '{16'h0008, 1'h0, 5'h0F, 5'h08, 3'h3}, '{16'h0008, 1'h0, 5'h10, 5'h09, 3'h6},
    '{16'h0158, 1'h0, 5'h01, 5'h04, 3'h1}, '{16'h0158, 1'h0, 5'h02, 5'h05, 3'h4},
    '{16'h02A8, 1'h0, 5'h04, 5'h02, 3'h1}, '{16'h02A8, 1'h0, 5'h05, 5'h03, 3'h4},
    '{16'h03F8, 1'h0, 5'h06, 5'h00, 3'h1}, '{16'h03F8, 1'h0, 5'h07, 5'h01, 3'h4},
    '{16'h0408, 1'h1, 5'h08, 5'h08, 3'h3}, '{16'h0408, 1'h1, 5'h09, 5'h09, 3'h6},
    '{16'h0558, 1'h1, 5'h0A, 5'h04, 3'h3}, '{16'h0558, 1'h1, 5'h0B, 5'h05, 3'h6},
    '{16'h06A8, 1'h1, 5'h0C, 5'h02, 3'h3}, '{16'h06A8, 1'h1, 5'h0D, 5'h03, 3'h6},
    '{16'h07F8, 1'h1, 5'h0E, 5'h00, 3'h1}, '{16'h07F8, 1'h1, 5'h0F, 5'h01, 3'h6},
    '{16'h0058, 1'h0, 5'h04, 5'h10, 3'h0}, '{16'h0058, 1'h0, 5'h05, 5'h10, 3'h2},
    '{16'h0058, 1'h1, 5'h02, 5'h00, 3'h1}, '{16'h0058, 1'h1, 5'h03, 5'h00, 3'h3},
    '{16'h0098, 1'h0, 5'h08, 5'h10, 3'h0}, '{16'h0098, 1'h0, 5'h09, 5'h10, 3'h2},
    '{16'h0100, 1'h0, 5'h10, 5'h10, 3'h2}};

  sftc_fifo_ctrl i_dut (
    .mclk_in(mclk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .levels_in(lv),
    .sync_mode_in(sync_mode), .cts_n_pin_in(cts_n), .rxd_pin_in(rxd),
    .tx_serial_in(tx_serial), .rts_out(rts), .cts_active_out(cts_act),
    .rx_full_out(rx_full), .tx_empty_out(tx_empty), .tx_fifo_clear_out(txclr),
    .rx_fifo_clear_out(rxclr), .rx_serial_out(rx_serial), .txd_pin_out(txd),
    .irq_out(irq));

  // Channel without flow control shares the bus wires
  sftc_fifo_ctrl #(.FLOW_CTRL(1'h0)) i_dut3 (
    .mclk_in(mclk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prdata3), .pready_out(), .pslverr_out(), .levels_in(lv),
    .sync_mode_in(sync_mode), .cts_n_pin_in(cts_n), .rxd_pin_in(rxd),
    .tx_serial_in(tx_serial), .rts_out(rts3), .cts_active_out(), .rx_full_out(),
    .tx_empty_out(), .tx_fifo_clear_out(), .rx_fifo_clear_out(), .rx_serial_out(),
    .txd_pin_out(), .irq_out());

  sftc_remote_model i_remote (
    .mclk_in(mclk), .rst_n_in(rst_n), .rts_in(rts), .stall_in(stall),
    .send_in(send), .bit_in(dbit), .cts_n_out(cts_n), .rxd_out(rxd));

  // Clock generation
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'h1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Let registered outputs land before looking at them
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  task end_of_test;
    $display("Comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, sync_mode, stall, send, dbit} = 8'h00;
    tx_serial = 1'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    lv = 10'h000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    apb(A_CTRL, 1'h0, 32'h0);
    chk_word(rd, 32'h0);
    foreach (rows[i]) begin
      apb(A_CTRL, 1'h1, {16'h0000, rows[i].fcr});
      lv        <= {rows[i].tx, rows[i].rx};
      sync_mode <= rows[i].sync;
      apb(A_CTRL, 1'h0, 32'h0);
      chk_word(rd, {16'h0000, rows[i].fcr});
      settle(2);
      chk_bit(rts, rows[i].exp[2]);
      chk_bit(rx_full, rows[i].exp[1]);
      chk_bit(tx_empty, rows[i].exp[0]);
      chk_bit(rts3, 1'h0);
    end
    // All ones written: reserved bits must drop out
    apb(A_CTRL, 1'h1, 32'hFFFFFFFF);
    apb(A_CTRL, 1'h0, 32'h0);
    chk_word(rd, 32'h000007FF);
    chk_word(prdata3, 32'h000000F7);
    settle(1);
    chk_bit(txclr, 1'h1);
    chk_bit(rxclr, 1'h1);
    // Loop-back: remote line ignored, pin idles high
    apb(A_CTRL, 1'h1, 32'h9);
    tx_serial <= 1'h0;
    send      <= 1'h1;
    dbit      <= 1'h1;
    settle(6);
    chk_bit(rx_serial, 1'h0);
    chk_bit(txd, 1'h1);
    chk_bit(txclr, 1'h0);
    chk_bit(rxclr, 1'h0);
    // Normal path, then the request stops the remote
    apb(A_CTRL, 1'h1, 32'h8);
    dbit      <= 1'h0;
    tx_serial <= 1'h1;
    lv        <= 10'h000;
    sync_mode <= 1'h0;
    settle(8);
    chk_bit(rx_serial, 1'h0);
    chk_bit(txd, 1'h1);
    @(posedge mclk);
    lv <= {5'h00, 5'h10};
    settle(8);
    chk_bit(rts, 1'h1);
    chk_bit(rx_serial, 1'h1);
    // Remote not ready, then modem control off forces send-permitted
    @(posedge mclk);
    stall <= 1'h1;
    settle(8);
    chk_bit(cts_act, 1'h0);
    apb(A_CTRL, 1'h1, 32'h0);
    settle(3);
    chk_bit(cts_act, 1'h1);
    chk_bit(rts, 1'h0);
    // Unmapped place: error, write dropped, reads zero
    apb(8'h40, 1'h1, 32'hFFFF);
    chk_bit(err, 1'h1);
    apb(8'h40, 1'h0, 32'h0);
    chk_bit(err, 1'h1);
    chk_word(rd, 32'h0);
    // Interrupt: raise, mask, clear
    @(posedge mclk);
    lv <= {5'h10, 5'h00};
    settle(3);
    apb(A_CLR, 1'h1, 32'h7);
    apb(A_STAT, 1'h0, 32'h0);
    chk_word(rd, 32'h0);
    apb(A_EN, 1'h1, 32'h2);
    lv <= {5'h10, 5'h02};
    settle(3);
    apb(A_STAT, 1'h0, 32'h0);
    chk_word(rd, 32'h2);
    apb(A_LVL, 1'h0, 32'h0);
    chk_word(rd, 32'h000A1002);
    settle(1);
    chk_bit(irq, 1'h1);
    apb(A_EN, 1'h1, 32'h0);
    settle(1);
    chk_bit(irq, 1'h0);
    apb(A_EN, 1'h1, 32'h2);
    settle(1);
    chk_bit(irq, 1'h1);
    apb(A_CLR, 1'h1, 32'h2);
    apb(A_STAT, 1'h0, 32'h0);
    chk_word(rd, 32'h0);
    settle(1);
    chk_bit(irq, 1'h0);
    // Transmit count falls from nine to eight with code zero
    @(posedge mclk);
    lv <= {5'h09, 5'h02};
    settle(2);
    chk_bit(tx_empty, 1'h0);
    @(posedge mclk);
    lv <= {5'h08, 5'h02};
    settle(2);
    chk_bit(tx_empty, 1'h1);
    apb(A_STAT, 1'h0, 32'h0);
    chk_word(rd, 32'h4);
    // Reset in mid-run must drop a written control word
    apb(A_CTRL, 1'h1, 32'h7FF);
    settle(1);
    chk_bit(txclr, 1'h1);
    @(posedge mclk);
    rst_n <= 1'h0;
    settle(1);
    chk_bit(txclr, 1'h0);
    chk_bit(rxclr, 1'h0);
    @(posedge mclk);
    rst_n <= 1'h1;
    apb(A_CTRL, 1'h0, 32'h0);
    chk_word(rd, 32'h0);
    end_of_test();
  end
endmodule : serial_fifo_trigger_control_tb
